// [design/tsr_pkg.sv]
// tsr_pkg: shared constants and types of the temperature sensor smbus readout block
package tsr_pkg;
	// smbus command codes (register offsets)
	localparam logic [7:0] cmd_local_int    = 8'h00;
	localparam logic [7:0] cmd_remote_int   = 8'h01;
	localparam logic [7:0] cmd_status1      = 8'h02;
	localparam logic [7:0] cmd_config_rd    = 8'h03;
	localparam logic [7:0] cmd_rate_rd      = 8'h04;
	localparam logic [7:0] cmd_config_wr    = 8'h09;
	localparam logic [7:0] cmd_rate_wr      = 8'h0a;
	localparam logic [7:0] cmd_single_conv  = 8'h0f;
	localparam logic [7:0] cmd_remote_frac  = 8'h10;
	localparam logic [7:0] cmd_local_frac   = 8'h11;
	localparam logic [7:0] cmd_status2      = 8'h12;
	// reset values, fault code and alert response address
	localparam logic [7:0] config_reset     = 8'h00;
	localparam logic [7:0] rate_reset       = 8'h06;
	localparam logic [7:0] temp_reset       = 8'h00;
	localparam logic [7:0] fault_code       = 8'h80;
	localparam logic [7:0] alert_resp_addr  = 8'h19;
	// field positions and highest rate with fractions
	localparam int         cfg_halt_bit     = 6;
	localparam int         cfg_chan_bit     = 3;
	localparam int         stat_fault_bit   = 2;
	localparam int         stat_busy_bit    = 7;
	localparam logic [7:0] rate_ext_max     = 8'h05;
	// slave address, arbitrary value
	localparam logic [6:0] slave_addr       = 7'h18;
	localparam logic [6:0] alert_resp_7b    = 7'h0c;
	// conversion time per channel slot in ns and in mclk cycles
	localparam int         clk_period_ns    = 10;
	localparam int         slot_time_ns     = 40000;
	localparam int         slot_cycles      = slot_time_ns / clk_period_ns;
	localparam int         rate_gap_cycles  = 4000;

	// one channel sample from the analog side
	typedef struct packed {
		logic [7:0] integer_part;
		logic [2:0] frac_part;
		logic       open_fault;
		logic       short_fault;
	} tsr_sample_type;

	// conversion sequencer states
	typedef enum logic [1:0] {
		conv_idle = 2'b00,
		conv_run  = 2'b01,
		conv_gap  = 2'b10
	} tsr_conv_state_type;

	// smbus link states
	typedef enum logic [2:0] {
		link_idle = 3'b000,
		link_rx   = 3'b001,
		link_ack  = 3'b010,
		link_tx   = 3'b011,
		link_mack = 3'b100,
		link_skip = 3'b101
	} tsr_link_state_type;
endpackage : tsr_pkg

// [design/tsr_top.sv]
// tsr_top: standby, conversion sequencing, register file and smbus slave of the sensor
//
// Summary of operation
// - standby stops automatic conversions
// - low standby pin or halt bit enters standby
// - standby keeps registers, bus alive, no timeout
// - one-shot converts in soft standby, not hard
// - standby pin overrides software conversion request
// - standby aborts conversion, keeps previous results
// - all data as 8-bit registers, one address
// - write, read, send, receive byte only
// - write byte stores data into selected register
// - read byte returns selected register, host nacks
// - send byte selects register, 0fh triggers conversion
// - receive byte reads last selected register
// - integer temperatures at 00h and 01h
// - config bit 3 selects remote channel
// - fraction bits at 10h and 11h when slow
// - integer and fraction update together
// - diode fault loads remote integer with 80h
// - diode fault sets status bit 2 of channel
// - alert asserts for open, not for short
// - no fault reported before first conversion
// - status read clears fault, releases alert
// - halt bit zero means free-running conversion
// - order remote 1, local, remote 1, remote 2
`timescale 1ns/1ps
module tsr_top (
	input  wire logic                    mclk,
	input  wire logic                    nrst,
	input  wire logic                    standby_pin_n,
	input  wire tsr_pkg::tsr_sample_type adc_sample,
	input  wire logic                    smb_clk,
	input  wire logic                    smb_data_in,
	output logic                         smb_data_out,
	output logic                         smb_data_oe,
	output logic                         alert_n,
	output logic [1:0]                   adc_channel,
	output logic                         adc_busy,
	output logic                         timeout_en
);
	////////////////////////////////////////////////////////////////////////////////
	// mclk domain: synchronisers
	logic standby_pin_n_s1_reg, standby_pin_n_s2_reg;
	logic tog_s1_reg, tog_s2_reg, tog_s3_reg;
	logic req_tog_reg; // link-domain toggle, one per completed command or write
	logic [7:0] lk_cmd_reg, lk_data_reg;
	logic       lk_wr_reg; // 1: write byte, 0: command only
	logic       lk_rd_done_tog_reg;
	logic rd_s1_reg, rd_s2_reg, rd_s3_reg;

	// pin and toggles pass two flops before use
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			standby_pin_n_s1_reg <= 1'b1;
			standby_pin_n_s2_reg <= 1'b1;
			tog_s1_reg  <= 1'b0;
			tog_s2_reg  <= 1'b0;
			tog_s3_reg  <= 1'b0;
			rd_s1_reg   <= 1'b0;
			rd_s2_reg   <= 1'b0;
			rd_s3_reg   <= 1'b0;
		end else begin
			standby_pin_n_s1_reg <= standby_pin_n;
			standby_pin_n_s2_reg <= standby_pin_n_s1_reg;
			tog_s1_reg  <= req_tog_reg;
			tog_s2_reg  <= tog_s1_reg;
			tog_s3_reg  <= tog_s2_reg;
			rd_s1_reg   <= lk_rd_done_tog_reg;
			rd_s2_reg   <= rd_s1_reg;
			rd_s3_reg   <= rd_s2_reg;
		end
	end

	wire req_evt = tog_s2_reg ^ tog_s3_reg; // command words are stable when the toggle arrives
	wire rd_evt  = rd_s2_reg ^ rd_s3_reg;

	////////////////////////////////////////////////////////////////////////////////
	// register file and conversion sequencer
	logic [7:0] cfg_reg, cfg_next, rate_reg, rate_next;
	logic [7:0] local_int_reg, local_int_next, local_frac_reg, local_frac_next;
	logic [7:0] r1_int_reg, r1_int_next, r1_frac_reg, r1_frac_next;
	logic [7:0] r2_int_reg, r2_int_next, r2_frac_reg, r2_frac_next;
	logic [7:0] ptr_reg, ptr_next;
	logic       f1_reg, f1_next, f2_reg, f2_next;      // status diode fault bits
	logic       o1_reg, o1_next, o2_reg, o2_next;      // open fault latched for alert
	logic       alert_n_next;
	tsr_pkg::tsr_conv_state_type st_reg, st_next;
	logic [1:0]  slot_reg, slot_next;
	logic [15:0] cnt_reg, cnt_next;
	tsr_pkg::tsr_sample_type s_r1a_reg, s_r1a_next, s_loc_reg, s_loc_next;
	tsr_pkg::tsr_sample_type s_r1b_reg, s_r1b_next;
	logic [7:0] rd_mirror_reg, rd_mirror_next; // read value handed to the link

	// fraction register layout: three bits at the top
	function automatic logic [7:0] frac_byte(input logic [2:0] f);
		frac_byte = {f, 5'h00};
	endfunction : frac_byte

	// register read mux shared by the link mirror
	function automatic logic [7:0] rd_mux(input logic [7:0] a, input logic [7:0] c,
		input logic [7:0] li, input logic [7:0] lf, input logic [7:0] ri,
		input logic [7:0] rf, input logic [7:0] s1, input logic [7:0] s2,
		input logic [7:0] r);
		if (a == tsr_pkg::cmd_local_int) rd_mux = li;
		else if (a == tsr_pkg::cmd_remote_int) rd_mux = ri;
		else if (a == tsr_pkg::cmd_status1) rd_mux = s1;
		else if (a == tsr_pkg::cmd_config_rd) rd_mux = c;
		else if (a == tsr_pkg::cmd_rate_rd) rd_mux = r;
		else if (a == tsr_pkg::cmd_remote_frac) rd_mux = rf;
		else if (a == tsr_pkg::cmd_local_frac) rd_mux = lf;
		else if (a == tsr_pkg::cmd_status2) rd_mux = s2;
		else rd_mux = 8'h00;
	endfunction : rd_mux

	wire hw_standby_pin_n = !standby_pin_n_s2_reg;
	wire sw_standby_pin_n = cfg_reg[tsr_pkg::cfg_halt_bit];
	wire ext_ok  = rate_reg <= tsr_pkg::rate_ext_max;
	wire chan2   = cfg_reg[tsr_pkg::cfg_chan_bit];

	// next-state of registers and sequencer
	always_comb begin
		logic [7:0] s1v, s2v, ri, rf;
		logic       oneshot, do_write;
		s1v = 8'h00;
		s2v = 8'h00;
		ri = 8'h00;
		rf = 8'h00;
		oneshot = 1'b0;
		do_write = 1'b0;
		cfg_next = cfg_reg;
		rate_next = rate_reg;
		local_int_next = local_int_reg;
		local_frac_next = local_frac_reg;
		r1_int_next = r1_int_reg;
		r1_frac_next = r1_frac_reg;
		r2_int_next = r2_int_reg;
		r2_frac_next = r2_frac_reg;
		ptr_next = ptr_reg;
		f1_next = f1_reg;
		f2_next = f2_reg;
		o1_next = o1_reg;
		o2_next = o2_reg;
		st_next = st_reg;
		slot_next = slot_reg;
		cnt_next = cnt_reg;
		s_r1a_next = s_r1a_reg;
		s_loc_next = s_loc_reg;
		s_r1b_next = s_r1b_reg;
		// link command: pointer update, writes, one-shot
		if (req_evt) begin
			ptr_next = lk_cmd_reg;
			do_write = lk_wr_reg;
			if (!lk_wr_reg && lk_cmd_reg == tsr_pkg::cmd_single_conv)
				oneshot = 1'b1;
		end
		if (do_write && lk_cmd_reg == tsr_pkg::cmd_config_wr)
			cfg_next = lk_data_reg;
		if (do_write && lk_cmd_reg == tsr_pkg::cmd_rate_wr)
			rate_next = lk_data_reg;
		if (do_write && lk_cmd_reg == tsr_pkg::cmd_single_conv)
			oneshot = 1'b1;
		// status read clears fault bits and alert
		if (rd_evt && ptr_reg == tsr_pkg::cmd_status1) begin
			f1_next = 1'b0;
			o1_next = 1'b0;
		end
		if (rd_evt && ptr_reg == tsr_pkg::cmd_status2) begin
			f2_next = 1'b0;
			o2_next = 1'b0;
		end
		// sequencer
		case (st_reg)
			tsr_pkg::conv_idle: begin
				if (!hw_standby_pin_n && (!sw_standby_pin_n || oneshot)) begin
					st_next = tsr_pkg::conv_run;
					slot_next = 2'd0;
					cnt_next = 16'd0;
				end
			end
			tsr_pkg::conv_run: begin
				if (hw_standby_pin_n || (do_write && lk_cmd_reg == tsr_pkg::cmd_config_wr
					&& lk_data_reg[tsr_pkg::cfg_halt_bit])) begin
					st_next = tsr_pkg::conv_idle;
				end else if (cnt_reg == 16'(tsr_pkg::slot_cycles - 1)) begin
					cnt_next = 16'd0;
					slot_next = slot_reg + 2'd1;
					if (slot_reg == 2'd0) s_r1a_next = adc_sample;
					if (slot_reg == 2'd1) s_loc_next = adc_sample;
					if (slot_reg == 2'd2) s_r1b_next = adc_sample;
					if (slot_reg == 2'd3) begin
						// commit all channels at once
						local_int_next = s_loc_reg.integer_part;
						local_frac_next = ext_ok ? frac_byte(s_loc_reg.frac_part) : 8'h00;
						r1_int_next = s_r1b_reg.integer_part;
						r1_frac_next = ext_ok ? frac_byte(s_r1b_reg.frac_part) : 8'h00;
						r2_int_next = adc_sample.integer_part;
						r2_frac_next = ext_ok ? frac_byte(adc_sample.frac_part) : 8'h00;
						if (s_r1b_reg.open_fault || s_r1b_reg.short_fault) begin
							r1_int_next = tsr_pkg::fault_code;
							r1_frac_next = 8'h00;
							f1_next = 1'b1;
							o1_next = s_r1b_reg.open_fault;
						end
						if (adc_sample.open_fault || adc_sample.short_fault) begin
							r2_int_next = tsr_pkg::fault_code;
							r2_frac_next = 8'h00;
							f2_next = 1'b1;
							o2_next = adc_sample.open_fault;
						end
						st_next = sw_standby_pin_n ? tsr_pkg::conv_idle : tsr_pkg::conv_gap;
					end
				end else begin
					cnt_next = cnt_reg + 16'd1;
				end
			end
			tsr_pkg::conv_gap: begin
				if (hw_standby_pin_n || sw_standby_pin_n) begin
					st_next = tsr_pkg::conv_idle;
				end else if (cnt_reg == 16'(tsr_pkg::rate_gap_cycles - 1)) begin
					st_next = tsr_pkg::conv_idle;
				end else begin
					cnt_next = cnt_reg + 16'd1;
				end
			end
			default: st_next = tsr_pkg::conv_idle;
		endcase
		s1v = 8'h00;
		s1v[tsr_pkg::stat_busy_bit] = st_reg == tsr_pkg::conv_run;
		s1v[tsr_pkg::stat_fault_bit] = f1_reg;
		s2v[tsr_pkg::stat_fault_bit] = f2_reg;
		ri = chan2 ? r2_int_reg : r1_int_reg;
		rf = chan2 ? r2_frac_reg : r1_frac_reg;
		rd_mirror_next = rd_mux(ptr_next, cfg_reg, local_int_reg, local_frac_reg, ri, rf,
			s1v, s2v, rate_reg);
		alert_n_next = !(o1_next || o2_next);
	end

	// registers keep contents through standby
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cfg_reg <= tsr_pkg::config_reset;
			rate_reg <= tsr_pkg::rate_reset;
			local_int_reg <= tsr_pkg::temp_reset;
			local_frac_reg <= tsr_pkg::temp_reset;
			r1_int_reg <= tsr_pkg::temp_reset;
			r1_frac_reg <= tsr_pkg::temp_reset;
			r2_int_reg <= tsr_pkg::temp_reset;
			r2_frac_reg <= tsr_pkg::temp_reset;
			ptr_reg <= 8'h00;
			f1_reg <= 1'b0;
			f2_reg <= 1'b0;
			o1_reg <= 1'b0;
			o2_reg <= 1'b0;
			st_reg <= tsr_pkg::conv_idle;
			slot_reg <= 2'd0;
			cnt_reg <= 16'd0;
			s_r1a_reg <= '0;
			s_loc_reg <= '0;
			s_r1b_reg <= '0;
			rd_mirror_reg <= 8'h00;
			alert_n <= 1'b1;
			adc_channel <= 2'd0;
			adc_busy <= 1'b0;
			timeout_en <= 1'b0;
		end else begin
			cfg_reg <= cfg_next;
			rate_reg <= rate_next;
			local_int_reg <= local_int_next;
			local_frac_reg <= local_frac_next;
			r1_int_reg <= r1_int_next;
			r1_frac_reg <= r1_frac_next;
			r2_int_reg <= r2_int_next;
			r2_frac_reg <= r2_frac_next;
			ptr_reg <= ptr_next;
			f1_reg <= f1_next;
			f2_reg <= f2_next;
			o1_reg <= o1_next;
			o2_reg <= o2_next;
			st_reg <= st_next;
			slot_reg <= slot_next;
			cnt_reg <= cnt_next;
			s_r1a_reg <= s_r1a_next;
			s_loc_reg <= s_loc_next;
			s_r1b_reg <= s_r1b_next;
			rd_mirror_reg <= rd_mirror_next;
			alert_n <= alert_n_next;
			adc_channel <= (slot_next == 2'd1) ? 2'd0 : ((slot_next == 2'd3) ? 2'd2 : 2'd1);
			adc_busy <= st_next == tsr_pkg::conv_run;
			timeout_en <= !(hw_standby_pin_n || sw_standby_pin_n);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// smbus link domain, clocked by the bus clock line
	logic       sda_pos_reg; // data level at the last rising bus clock
	logic [2:0] ph_reg; // link-side phase: 0 addr, 1 cmd, 2 data, 3 read
	tsr_pkg::tsr_link_state_type ls_reg;
	logic [3:0] bit_reg;
	logic [7:0] sh_reg;
	logic [7:0] rd_m1_reg, rd_m2_reg;
	logic       start_reg;   // start seen, stands over one rising bus clock

	// a data fall between a rising and the next falling bus clock is a start
	always_ff @(negedge smb_clk or negedge nrst) begin
		if (!nrst) begin
			start_reg <= 1'b0;
		end else begin
			start_reg <= sda_pos_reg && !smb_data_in;
		end
	end

	// byte engine: address, command, data or read-back
	always_ff @(posedge smb_clk or negedge nrst) begin
		if (!nrst) begin
			ls_reg <= tsr_pkg::link_rx;
			ph_reg <= 3'd0;
			bit_reg <= 4'd0;
			sh_reg <= 8'h00;
			lk_cmd_reg <= 8'h00;
			lk_data_reg <= 8'h00;
			lk_wr_reg <= 1'b0;
			req_tog_reg <= 1'b0;
			lk_rd_done_tog_reg <= 1'b0;
			rd_m1_reg <= 8'h00;
			rd_m2_reg <= 8'h00;
			sda_pos_reg <= 1'b1;
		end else begin
			sda_pos_reg <= smb_data_in;
			rd_m1_reg <= rd_mirror_reg;
			rd_m2_reg <= rd_m1_reg;
			case (ls_reg)
				tsr_pkg::link_rx: begin
					sh_reg <= {sh_reg[6:0], smb_data_in};
					bit_reg <= bit_reg + 4'd1;
					if (bit_reg == 4'd7) ls_reg <= tsr_pkg::link_ack;
				end
				tsr_pkg::link_ack: begin // byte closes: address, command or data
					bit_reg <= 4'd0;
					ls_reg <= tsr_pkg::link_rx;
					if (ph_reg == 3'd0) begin
						if (sh_reg[7:1] == tsr_pkg::slave_addr && sh_reg[0]) begin
							ls_reg <= tsr_pkg::link_tx;
							ph_reg <= 3'd3;
							sh_reg <= rd_m2_reg;
						end else if (sh_reg[7:1] == tsr_pkg::slave_addr) begin
							ph_reg <= 3'd1;
						end else begin
							ls_reg <= tsr_pkg::link_skip;
						end
					end else if (ph_reg == 3'd1) begin
						lk_cmd_reg <= sh_reg;
						lk_wr_reg <= 1'b0;
						req_tog_reg <= ~req_tog_reg;
						ph_reg <= 3'd2;
					end else begin
						lk_data_reg <= sh_reg;
						lk_wr_reg <= 1'b1;
						req_tog_reg <= ~req_tog_reg;
						ph_reg <= 3'd0;
					end
				end
				tsr_pkg::link_tx: begin
					sh_reg <= {sh_reg[6:0], 1'b0};
					bit_reg <= bit_reg + 4'd1;
					if (bit_reg == 4'd7) ls_reg <= tsr_pkg::link_mack;
				end
				tsr_pkg::link_mack: begin
					lk_rd_done_tog_reg <= ~lk_rd_done_tog_reg;
					ph_reg <= 3'd0;
					bit_reg <= 4'd0;
					ls_reg <= tsr_pkg::link_rx;
				end
				default: ls_reg <= tsr_pkg::link_skip;
			endcase
			if (start_reg) begin // a start reframes: this clock carries the first address bit
				ls_reg <= tsr_pkg::link_rx;
				ph_reg <= 3'd0;
				sh_reg <= {7'h00, smb_data_in};
				bit_reg <= 4'd1;
			end
		end
	end

	// line driver changes while the bus clock is low
	always_ff @(negedge smb_clk or negedge nrst) begin
		if (!nrst) begin
			smb_data_out <= 1'b1;
			smb_data_oe <= 1'b0;
		end else begin
			smb_data_out <= (ls_reg == tsr_pkg::link_tx) ? sh_reg[7] : 1'b0;
			smb_data_oe <= (ls_reg == tsr_pkg::link_ack &&
				(ph_reg != 3'd0 || sh_reg[7:1] == tsr_pkg::slave_addr)) ||
				(ls_reg == tsr_pkg::link_tx && !sh_reg[7]);
		end
	end
endmodule : tsr_top

// [tb/tsr_checker.sv]
// tsr_checker: concurrent checks on the ports of the sensor readout block
`timescale 1ns/1ps
module tsr_checker (
	input wire logic                    mclk,
	input wire logic                    nrst,
	input wire logic                    standby_pin_n,
	input wire tsr_pkg::tsr_sample_type adc_sample,
	input wire logic                    smb_clk,
	input wire logic                    smb_data_in,
	input wire logic                    smb_data_out,
	input wire logic                    smb_data_oe,
	input wire logic                    alert_n,
	input wire logic [1:0]              adc_channel,
	input wire logic                    adc_busy,
	input wire logic                    timeout_en
);
	localparam int slot_len = tsr_pkg::slot_cycles;
	logic [15:0] slot_cnt_reg;
	logic [15:0] slot_cnt_next;
	logic [1:0]  chan_reg;
	logic [1:0]  chan_next;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////////////////////////
	// counts cycles spent on one channel inside a conversion
	always_comb begin
		chan_next     = adc_channel;
		slot_cnt_next = (adc_busy && adc_channel == chan_reg) ? slot_cnt_reg + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			slot_cnt_reg <= 16'h0000;
			chan_reg     <= 2'h0;
		end else begin
			slot_cnt_reg <= slot_cnt_next;
			chan_reg     <= chan_next;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// standby pin held low long enough to pass the synchroniser
	sequence s_pin_held;
		!standby_pin_n [*6];
	endsequence
	// a conversion has just started and settled
	sequence s_conv_begun;
		$rose(adc_busy) ##2 1'b1;
	endsequence
	AST_HW_STANDBY_IDLE: assert property (s_pin_held |-> !adc_busy)
		else $error("conversion runs with standby pin low");
	AST_HW_STANDBY_NO_TIMEOUT: assert property (s_pin_held |-> !timeout_en)
		else $error("bus timeout enabled in hardware standby");
	AST_FIRST_SLOT_REMOTE1: assert property (s_conv_begun |-> (adc_busy && adc_channel == 2'd1) [*8])
		else $error("conversion does not start on remote 1");
	AST_CHANNEL_ORDER: assert property (adc_busy && $past(adc_busy) && $changed(adc_channel)
		&& adc_channel != 2'd1 |-> $past(adc_channel) == 2'd1)
		else $error("local or remote 2 slot not preceded by remote 1");
	AST_SLOT_BOUND: assert property (slot_cnt_reg <= slot_len)
		else $error("channel slot runs longer than its conversion time");
	AST_DRIVE_LOW_ONLY: assert property (smb_data_oe |-> !smb_data_out)
		else $error("data line driven high");
	AST_BIT_STABLE: assert property (smb_clk && $past(smb_clk) |-> $stable(smb_data_oe))
		else $error("data drive changed while bus clock high");
	AST_ALERT_AT_CONV_END: assert property ($fell(alert_n)
		|-> $past(adc_busy, 1) || $past(adc_busy, 2) || $past(adc_busy, 3))
		else $error("alert asserted away from a conversion end");
endmodule : tsr_checker
bind tsr_top tsr_checker tsr_checker_i (.mclk(mclk), .nrst(nrst), .standby_pin_n(standby_pin_n),
	.adc_sample(adc_sample), .smb_clk(smb_clk), .smb_data_in(smb_data_in),
	.smb_data_out(smb_data_out), .smb_data_oe(smb_data_oe), .alert_n(alert_n),
	.adc_channel(adc_channel), .adc_busy(adc_busy), .timeout_en(timeout_en));

// [tb/tsr_host_model.sv]
// tsr_host_model: bus host that runs the four byte transactions on the two-wire link
`timescale 1ns/1ps
module tsr_host_model (
	output logic     smb_clk,
	output logic     smb_data_in,
	input wire logic smb_data_out,
	input wire logic smb_data_oe
);
	logic host_pull;
	// open-drain data line with pull-up: low if either side pulls
	assign smb_data_in = !(host_pull || (smb_data_oe && !smb_data_out));
	initial begin
		smb_clk   = 1'b1;
		host_pull = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// one bit of a 48 ns clock; clock stands high between frames
	task automatic clk_bit(input logic drv, output logic seen);
		smb_clk = 1'b0;
		#12 host_pull = !drv;
		#12 smb_clk = 1'b1;
		seen = smb_data_in;
		#24;
	endtask : clk_bit
	// clocks given while the device is held in reset
	task automatic pulses(input int n);
		logic s;
		for (int i = 0; i < n; i++) clk_bit(1'b1, s);
	endtask : pulses
	// start or repeated start: data released with the clock low, then falls while high
	task automatic start();
		smb_clk = 1'b0;
		#12 host_pull = 1'b0;
		#12 smb_clk = 1'b1;
		#12 host_pull = 1'b1;
		#12;
	endtask : start
	// stop: data pulled with the clock low, then rises while high
	task automatic stop();
		smb_clk = 1'b0;
		#12 host_pull = 1'b1;
		#12 smb_clk = 1'b1;
		#12 host_pull = 1'b0;
		#12;
	endtask : stop
	// msb first, then the device's acknowledge
	task automatic byte_out(input logic [7:0] v, inout logic ok);
		logic s;
		for (int i = 7; i >= 0; i--) clk_bit(v[i], s);
		clk_bit(1'b1, s);
		ok = ok & !s;
	endtask : byte_out
	// one byte from the device, closed by a host not-acknowledge
	task automatic byte_in(output logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, s);
			v[i] = s;
		end
		clk_bit(1'b1, s);
	endtask : byte_in
	////////////////////////////////////////////////////////////////////////////////
	task automatic write_byte(input logic [7:0] cmd, input logic [7:0] data, output logic ok);
		ok = 1'b1;
		start();
		byte_out({tsr_pkg::slave_addr, 1'b0}, ok);
		byte_out(cmd, ok);
		byte_out(data, ok);
		stop();
	endtask : write_byte
	task automatic read_byte(input logic [7:0] cmd, output logic [7:0] data, output logic ok);
		ok = 1'b1;
		start();
		byte_out({tsr_pkg::slave_addr, 1'b0}, ok);
		byte_out(cmd, ok);
		start();
		byte_out({tsr_pkg::slave_addr, 1'b1}, ok);
		byte_in(data);
		stop();
	endtask : read_byte
	task automatic send_byte(input logic [7:0] cmd, output logic ok);
		ok = 1'b1;
		start();
		byte_out({tsr_pkg::slave_addr, 1'b0}, ok);
		byte_out(cmd, ok);
		stop();
	endtask : send_byte
	task automatic receive_byte(output logic [7:0] data, output logic ok);
		ok = 1'b1;
		start();
		byte_out({tsr_pkg::slave_addr, 1'b1}, ok);
		byte_in(data);
		stop();
	endtask : receive_byte
endmodule : tsr_host_model

// [tb/test_tsr_top.sv]
// test_tsr_top: register-level bench of the temperature sensor readout
`timescale 1ns/1ps
module test_tsr_top;
	logic                    mclk;
	logic                    nrst;
	logic                    standby_pin_n;
	tsr_pkg::tsr_sample_type adc_sample;
	tsr_pkg::tsr_sample_type samp [0:3];
	logic                    smb_clk;
	logic                    smb_data_in;
	logic                    smb_data_out;
	logic                    smb_data_oe;
	logic                    alert_n;
	logic [1:0]              adc_channel;
	logic                    adc_busy;
	logic                    timeout_en;
	logic [7:0]              d;
	logic                    ok;
	int                      n_mismatch;
	int                      compares;
	localparam int fb = tsr_pkg::stat_fault_bit;
	tsr_top tsr_top_i (.mclk(mclk), .nrst(nrst), .standby_pin_n(standby_pin_n),
		.adc_sample(adc_sample), .smb_clk(smb_clk), .smb_data_in(smb_data_in),
		.smb_data_out(smb_data_out), .smb_data_oe(smb_data_oe), .alert_n(alert_n),
		.adc_channel(adc_channel), .adc_busy(adc_busy), .timeout_en(timeout_en));
	tsr_host_model tsr_host_model_i (.smb_clk(smb_clk), .smb_data_in(smb_data_in),
		.smb_data_out(smb_data_out), .smb_data_oe(smb_data_oe));
	initial mclk = 1'b0;
	always #5 mclk = ~mclk;
	// analog side answers for the channel in conversion
	always @(posedge mclk) adc_sample <= samp[adc_channel];
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", what, exp, got);
			n_mismatch++;
		end
	endtask : chk8
	task automatic chk1(input string what, input logic exp, input logic got);
		chk8(what, {7'h00, exp}, {7'h00, got});
	endtask : chk1
	task automatic rd(input logic [7:0] cmd, output logic [7:0] v);
		logic a;
		tsr_host_model_i.read_byte(cmd, v, a);
		chk1("read ack", 1'b1, a);
	endtask : rd
	task automatic wr(input logic [7:0] cmd, input logic [7:0] v);
		logic a;
		tsr_host_model_i.write_byte(cmd, v, a);
		chk1("write ack", 1'b1, a);
	endtask : wr
	task automatic give_verdict();
		if (n_mismatch == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : give_verdict
	// bounded wait on busy (sel 0) or alert (sel 1)
	task automatic wait_for(input int sel, input logic lvl, input int lim);
		int n;
		n = 0;
		while (((sel == 0) ? adc_busy : alert_n) !== lvl && n < lim) begin
			@(posedge mclk);
			#1 n++;
		end
		if (n >= lim) begin
			$display("[ERR] wait %0d expected %b seen timeout", sel, lvl);
			n_mismatch++;
			give_verdict();
		end
	endtask : wait_for
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		nrst = 1'b0;
		standby_pin_n = 1'b1;
		adc_sample = '0;
		samp[0] = '{8'h19, 3'h2, 1'b0, 1'b0};
		samp[1] = '{8'he7, 3'h5, 1'b0, 1'b0};
		samp[2] = '{8'h42, 3'h7, 1'b0, 1'b1};
		samp[3] = '0;
		tsr_host_model_i.pulses(4);
		repeat (16) @(posedge mclk);
		nrst <= 1'b1;
		repeat (4) @(posedge mclk);
		rd(tsr_pkg::cmd_status2, d);
		chk1("fault before first conversion", 1'b0, d[fb]);
		rd(tsr_pkg::cmd_rate_rd, d);
		chk8("rate reset", 8'h06, d);
		wait_for(0, 1'b1, 5000);
		wait_for(0, 1'b0, 25000);
		chk1("timeout running", 1'b1, timeout_en);
		rd(tsr_pkg::cmd_local_int, d);
		chk8("local integer", 8'h19, d);
		rd(tsr_pkg::cmd_remote_int, d);
		chk8("remote 1 integer", 8'he7, d);
		rd(tsr_pkg::cmd_remote_frac, d);
		chk8("fraction at fast rate", 8'h00, d & 8'he0);
		rd(tsr_pkg::cmd_status2, d);
		chk1("short fault", 1'b1, d[fb]);
		chk1("no alert on short", 1'b1, alert_n);
		tsr_host_model_i.receive_byte(d, ok);
		chk1("receive ack", 1'b1, ok);
		chk1("fault cleared by read", 1'b0, d[fb]);
		wr(tsr_pkg::cmd_config_wr, 8'h01 << tsr_pkg::cfg_chan_bit);
		rd(tsr_pkg::cmd_remote_int, d);
		chk8("remote 2 fault code", 8'h80, d);
		wr(tsr_pkg::cmd_rate_wr, 8'h05);
		wr(tsr_pkg::cmd_config_wr, 8'h00);
		samp[0] <= '{8'h1a, 3'h6, 1'b0, 1'b0};
		samp[1] <= '{8'h2c, 3'h3, 1'b1, 1'b0};
		samp[2] <= '{8'h42, 3'h7, 1'b0, 1'b0};
		wait_for(0, 1'b1, 5000);
		wait_for(0, 1'b0, 20000);
		wait_for(1, 1'b0, 10);
		rd(tsr_pkg::cmd_remote_int, d);
		chk8("open fault code", 8'h80, d);
		rd(tsr_pkg::cmd_local_int, d);
		chk8("local integer slow", 8'h1a, d);
		rd(tsr_pkg::cmd_local_frac, d);
		chk8("local fraction", 8'hc0, d & 8'he0);
		rd(tsr_pkg::cmd_status1, d);
		chk1("open fault", 1'b1, d[fb]);
		wait_for(1, 1'b1, 50);
		samp[1] <= '{8'h2c, 3'h3, 1'b0, 1'b0};
		wait_for(0, 1'b1, 6000);
		repeat (100) @(posedge mclk);
		samp[0] <= '{8'h33, 3'h1, 1'b0, 1'b0};
		standby_pin_n <= 1'b0;
		wait_for(0, 1'b0, 10);
		chk1("timeout off in standby", 1'b0, timeout_en);
		rd(tsr_pkg::cmd_local_int, d);
		chk8("result kept after abort", 8'h1a, d);
		wr(tsr_pkg::cmd_single_conv, 8'h00);
		repeat (200) @(posedge mclk);
		#1 chk1("one-shot ignored", 1'b0, adc_busy);
		wr(tsr_pkg::cmd_config_wr, 8'h01 << tsr_pkg::cfg_halt_bit);
		@(posedge mclk) standby_pin_n <= 1'b1;
		repeat (6000) @(posedge mclk);
		#1 chk1("soft standby idle", 1'b0, adc_busy);
		chk1("timeout off soft", 1'b0, timeout_en);
		wr(tsr_pkg::cmd_single_conv, 8'h00);
		wait_for(0, 1'b1, 2000);
		wait_for(0, 1'b0, 20000);
		rd(tsr_pkg::cmd_local_int, d);
		chk8("one-shot result", 8'h33, d);
		samp[0] <= '{8'h44, 3'h0, 1'b0, 1'b0};
		tsr_host_model_i.send_byte(tsr_pkg::cmd_single_conv, ok);
		chk1("send ack", 1'b1, ok);
		wait_for(0, 1'b1, 2000);
		wr(tsr_pkg::cmd_config_wr, 8'h01 << tsr_pkg::cfg_halt_bit);
		wait_for(0, 1'b0, 10);
		rd(tsr_pkg::cmd_local_int, d);
		chk8("result kept after soft abort", 8'h33, d);
		give_verdict();
	end
endmodule : test_tsr_top
